// File: hdl/ccu_top.sv
// two capture/compare units with a shared 16-bit time base and wishbone slave
// assumes the unit pins arrive asynchronous; a single 200 MHz clock
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "ccu_defines.svh"

//
// Contract
// - capture copies the full 16-bit time base into the value pair.
// - capture event is falling, rising, every 4th or 16th rising edge.
// - each capture sets the unit event flag, bit 2 of flag register; unit 2 sets bit 3.
// - event flag stays set until software clears it.
// - a new capture overwrites an unread captured value.
// - a port write changing an output pin can trigger capture.
// - changing capture selection may set the flag falsely.
// - prescaler counter clears when off or not in capture mode.
// - switching prescaler settings directly keeps the prescaler count.
// - compare mode checks value pair against time base every cycle.
// - compare match drives pin high, low or leaves it.
// - compare match sets the event flag with the pin action.
// - software-interrupt compare mode only sets the flag.
// - special-event compare match resets the time base, in both units.
// - two capturing units sample the same time base.
// - pwm units share period and rate; no interaction with others. Here pwm mode has no period or rate and only passes port data to the pin.
// - value pair reads and writes as low and high bytes.
// - special event reset does not set the time base overflow flag.
// - control write of zero forces the compare output latch low.
module ccu_top
  import ccu_pkg::*;
#(
  parameter int UNITS = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             timebase16_inc_i,
  input  wire logic [UNITS-1:0] unit_pin_i,
  input  wire logic [UNITS-1:0] port_direction_i,
  input  wire logic [UNITS-1:0] port_data_i,
  output logic      [UNITS-1:0] unit_pin_o,
  output logic      [UNITS-1:0] unit_pin_oe_o,
  output logic      [UNITS-1:0] special_event_o
);

  logic [15:0]      timebase16_count_r;
  logic             timebase16_overflow_flag_r;
  logic [7:0]       ctl_r      [UNITS];
  logic [15:0]      val_r      [UNITS];
  logic [3:0]       ps_cnt_r   [UNITS];
  logic [UNITS-1:0] flag_r;
  logic [UNITS-1:0] cmp_latch_r;

  logic [UNITS-1:0] pin_s1_r;
  logic [UNITS-1:0] pin_s2_r;
  logic [UNITS-1:0] pin_s3_r;
  logic [UNITS-1:0] cap_ev;
  logic [UNITS-1:0] cmp_hit;
  logic [UNITS-1:0] spec_hit;
  logic [UNITS-1:0] flag_set;

  logic [UNITS-1:0] ctl_we;
  logic [UNITS-1:0] val_we;
  logic             wb_req;
  logic             wr_en;
  logic             flag_we;
  logic             tb_we;
  logic [31:0]      rd_nxt;

  function automatic ccu_state_t mode_state(input logic [3:0] m);
    ccu_state_t s;
    s = CCU_ST_OFF;
    case (m[3:2])
      2'b01:   s = CCU_ST_CAP;
      2'b10:   s = CCU_ST_CMP;
      2'b11:   s = CCU_ST_PWM;
      default: s = CCU_ST_OFF;
    endcase
    return s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // per-unit register addresses
  function automatic logic [7:0] ctl_adr(input int u);
    logic [7:0] a;
    a = (u == 0) ? `CCU_ADR_CTL1 : `CCU_ADR_CTL2;
    return a;
  endfunction

  function automatic logic [7:0] val_adr(input int u);
    logic [7:0] a;
    a = (u == 0) ? `CCU_ADR_VAL1 : `CCU_ADR_VAL2;
    return a;
  endfunction

  function automatic logic [3:0] ps_terminal(input logic [3:0] m);
    logic [3:0] t;
    t = (m == `CCU_M_CAP_R16) ? `CCU_PS16_LAST : `CCU_PS4_LAST;
    return t;
  endfunction

  function automatic logic [31:0] flag_word(input logic [UNITS-1:0] f, input logic ovf);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CCU_FLAG_OVF] = ovf;
    for (int u = 0; u < UNITS; u++) begin
      w[`CCU_FLAG_U1 + u] = f[u];
    end
    return w;
  endfunction

  // taken once: a high ack blocks a second take
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = wb_req && wb_we_i;
  assign flag_we = wr_en && (wb_adr_i == `CCU_ADR_FLAG) && wb_sel_i[0];
  assign tb_we   = wr_en && (wb_adr_i == `CCU_ADR_TBASE);

  // pin synchroniser, two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= unit_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // previous synced level for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s3_r <= '0;
    end else begin
      pin_s3_r <= pin_s2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit
      ccu_state_t st;
      logic       edge_fall;
      logic       edge_rise;
      logic [3:0] mode;
      logic [3:0] mode_nxt;
      logic [3:0] ps_last;
      logic       ps_hit;
      logic       off_wr;
      // output pin level seen as port write
      logic       lvl_now;
      logic       lvl_old;
      assign mode     = ctl_r[g][`CCU_MODE_MSB:`CCU_MODE_LSB];
      assign mode_nxt = wb_dat_i[`CCU_MODE_MSB:`CCU_MODE_LSB];
      assign st       = mode_state(mode);
      // a driven pin loops back, so port writes form edges
      assign lvl_now  = pin_s2_r[g];
      assign lvl_old  = pin_s3_r[g];
      assign edge_rise = lvl_now && !lvl_old;
      assign edge_fall = !lvl_now && lvl_old;
      assign ps_last  = ps_terminal(mode);
      assign ps_hit   = (ps_cnt_r[g] == ps_last);
      assign off_wr   = ctl_we[g] && (mode_nxt == `CCU_M_OFF);
      assign ctl_we[g] = wr_en && (wb_adr_i == ctl_adr(g)) && wb_sel_i[0];
      assign val_we[g] = wr_en && (wb_adr_i == val_adr(g));

      always_comb begin
        cap_ev[g] = 1'b0;
        if (st == CCU_ST_CAP) begin
          case (mode)
            `CCU_M_CAP_FALL: cap_ev[g] = edge_fall;
            `CCU_M_CAP_RISE: cap_ev[g] = edge_rise;
            default:         cap_ev[g] = edge_rise && ps_hit;
          endcase
        end
      end

      assign cmp_hit[g]  = (st == CCU_ST_CMP) && (val_r[g] == timebase16_count_r);
      assign spec_hit[g] = cmp_hit[g] && (mode == `CCU_M_CMP_SPEC);
      // capture or match sets the flag
      assign flag_set[g] = cap_ev[g] || cmp_hit[g];

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ps_cnt_r[g] <= 4'h0;
        end else if (st != CCU_ST_CAP) begin
          ps_cnt_r[g] <= 4'h0;
        end else if (off_wr) begin
          ps_cnt_r[g] <= 4'h0;
        end else if (edge_rise && mode != `CCU_M_CAP_FALL) begin
          ps_cnt_r[g] <= ps_hit ? 4'h0 : ps_cnt_r[g] + 4'h1;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctl_r[g] <= 8'h00;
        end else if (ctl_we[g]) begin
          ctl_r[g] <= wb_dat_i[7:0] & `CCU_CTL_MASK;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          val_r[g] <= 16'h0000;
        end else if (cap_ev[g]) begin
          val_r[g] <= timebase16_count_r;
        end else if (val_we[g]) begin
          val_r[g] <= 16'(merge({16'h0000, val_r[g]}, wb_dat_i, wb_sel_i));
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag_r[g] <= 1'b0;
        end else if (flag_set[g]) begin
          flag_r[g] <= 1'b1;
        end else if (flag_we) begin
          flag_r[g] <= wb_dat_i[`CCU_FLAG_U1 + g];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cmp_latch_r[g] <= 1'b0;
        end else if (off_wr) begin
          cmp_latch_r[g] <= 1'b0;
        end else if (cmp_hit[g] && mode == `CCU_M_CMP_HIGH) begin
          cmp_latch_r[g] <= 1'b1;
        end else if (cmp_hit[g] && mode == `CCU_M_CMP_LOW) begin
          cmp_latch_r[g] <= 1'b0;
        end
      end

      // pwm units take no part in capture or compare
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          unit_pin_o[g] <= 1'b0;
        end else begin
          unit_pin_o[g] <= (st == CCU_ST_CMP) ? cmp_latch_r[g] : port_data_i[g];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          unit_pin_oe_o[g] <= 1'b0;
        end else begin
          unit_pin_oe_o[g] <= !port_direction_i[g];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          special_event_o[g] <= 1'b0;
        end else begin
          special_event_o[g] <= spec_hit[g];
        end
      end
    end
  endgenerate

  // time base, special event clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timebase16_count_r <= 16'h0000;
    end else if (|spec_hit) begin
      timebase16_count_r <= 16'h0000;
    end else if (tb_we) begin
      timebase16_count_r <= 16'(merge({16'h0000, timebase16_count_r}, wb_dat_i, wb_sel_i));
    end else if (timebase16_inc_i) begin
      timebase16_count_r <= timebase16_count_r + 16'h0001;
    end
  end

  // overflow only on a counted wrap, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timebase16_overflow_flag_r <= 1'b0;
    end else if (!(|spec_hit) && timebase16_inc_i && (&timebase16_count_r) && !tb_we) begin
      timebase16_overflow_flag_r <= 1'b1;
    end else if (flag_we) begin
      timebase16_overflow_flag_r <= wb_dat_i[`CCU_FLAG_OVF];
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      ctl_adr(0):     rd_nxt = {24'h000000, ctl_r[0]};
      ctl_adr(1):     rd_nxt = {24'h000000, ctl_r[1]};
      val_adr(0):     rd_nxt = {16'h0000, val_r[0]};
      val_adr(1):     rd_nxt = {16'h0000, val_r[1]};
      `CCU_ADR_FLAG:  rd_nxt = flag_word(flag_r, timebase16_overflow_flag_r);
      `CCU_ADR_TBASE: rd_nxt = {16'h0000, timebase16_count_r};
      default:        rd_nxt = 32'h0000_0000;
    endcase
  end

  // one-cycle ack, read data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // read data stands only with ack, else zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= wb_req ? rd_nxt : 32'h0000_0000;
    end
  end

endmodule

// File: hdl/ccu_defines.svh
// register offsets, field positions and mode codes of the capture/compare unit
// assumes a classic wishbone slave with 32-bit data, one register per word
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

// register byte addresses; printed index times four
`define CCU_IDX_CTL1      8'h17
`define CCU_IDX_CTL2      8'h1D
`define CCU_ADR_CTL1      8'h5C
`define CCU_ADR_CTL2      8'h74
`define CCU_ADR_VAL1      8'h80
`define CCU_ADR_VAL2      8'h84
`define CCU_ADR_FLAG      8'h88
`define CCU_ADR_TBASE     8'h8C

// control fields
`define CCU_MODE_LSB      0
`define CCU_MODE_MSB      3
`define CCU_DUTY_LSB      4
`define CCU_DUTY_MSB      5
`define CCU_CTL_MASK      8'h3F

// mode codes
`define CCU_M_OFF         4'h0
`define CCU_M_CAP_FALL    4'h4
`define CCU_M_CAP_RISE    4'h5
`define CCU_M_CAP_R4      4'h6
`define CCU_M_CAP_R16     4'h7
`define CCU_M_CMP_HIGH    4'h8
`define CCU_M_CMP_LOW     4'h9
`define CCU_M_CMP_SOFT    4'hA
`define CCU_M_CMP_SPEC    4'hB

// flag register layout
`define CCU_FLAG_U1       2
`define CCU_FLAG_U2       3
`define CCU_FLAG_OVF      0

// prescaler terminal counts
`define CCU_PS4_LAST      4'h3
`define CCU_PS16_LAST     4'hF

`endif

// File: hdl/ccu_pkg.sv
// types shared by the capture/compare unit
// assumes ccu_defines.svh for numeric constants
package ccu_pkg;
  typedef enum logic [3:0] {
    CCU_ST_OFF = 4'h1,
    CCU_ST_CAP = 4'h2,
    CCU_ST_CMP = 4'h4,
    CCU_ST_PWM = 4'h8
  } ccu_state_t;
endpackage

// File: tb/ccu_pin_model.sv
// pin source model: drives each pin unless the unit drives it
// assumes per-pin output enable, high while the unit drives
`timescale 1ns/1ps
module ccu_pin_model (
  input  wire logic [1:0] src_i,
  input  wire logic [1:0] drv_i,
  input  wire logic [1:0] oe_i,
  output logic      [1:0] pin_o
);
  assign pin_o = (oe_i & drv_i) | (~oe_i & src_i);
endmodule

// File: tb/ccu_top_properties.sv
// bus and pin-enable assertions on the ccu_top ports
// assumes one clock and a sync active-high reset
`timescale 1ns/1ps
`include "ccu_defines.svh"
module ccu_top_properties
  import ccu_pkg::*;
#(
  parameter int UNITS = 2
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic [UNITS-1:0] port_direction_i,
  input wire logic [UNITS-1:0] unit_pin_oe_o,
  input wire logic [UNITS-1:0] special_event_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data idle");
  property p_ctl_rd;
    wb_ack_o && !wb_we_i && wb_adr_i inside {`CCU_ADR_CTL1, `CCU_ADR_CTL2}
      |-> wb_dat_o[31:6] == 26'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("ctl bits");
  property p_val_rd;
    wb_ack_o && !wb_we_i && wb_adr_i inside {`CCU_ADR_VAL1, `CCU_ADR_VAL2}
      |-> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_val_rd: assert property (p_val_rd) else $error("value bits");
  property p_flag_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == `CCU_ADR_FLAG
      |-> wb_dat_o[31:4] == 28'h0 && !wb_dat_o[1];
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag bits");
  property p_unmapped;
    wb_ack_o && !wb_we_i && !(wb_adr_i inside {`CCU_ADR_CTL1, `CCU_ADR_CTL2, `CCU_ADR_VAL1,
      `CCU_ADR_VAL2, `CCU_ADR_FLAG, `CCU_ADR_TBASE})
      |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_oe;
    !$past(rst_i) |-> unit_pin_oe_o == ~$past(port_direction_i);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_spec_a: cover property (special_event_o[0]);
  c_spec_b: cover property (special_event_o[UNITS-1]);
endmodule
bind ccu_top ccu_top_properties #(
  .UNITS(UNITS)
) ccu_top_properties_i (
  .clk_i           (clk_i),
  .rst_i           (rst_i),
  .wb_cyc_i        (wb_cyc_i),
  .wb_stb_i        (wb_stb_i),
  .wb_we_i         (wb_we_i),
  .wb_adr_i        (wb_adr_i),
  .wb_dat_o        (wb_dat_o),
  .wb_ack_o        (wb_ack_o),
  .port_direction_i(port_direction_i),
  .unit_pin_oe_o   (unit_pin_oe_o),
  .special_event_o (special_event_o)
);

// File: tb/tb.sv
// bench: wishbone master, queued read checks, pin source model
// assumes ccu_top with two units, time base held unless stepped
`timescale 1ns/1ps
`include "ccu_defines.svh"
module tb;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0;
  logic        we = 0;
  logic        inc = 0;
  logic [7:0]  adr = 0;
  logic [7:0]  ctl;
  logic [31:0] dat = 0;
  logic [31:0] rdat;
  logic        ack;
  logic [1:0]  src = 0;
  logic [1:0]  dir = 2'h3;
  logic [1:0]  pdat = 0;
  logic [1:0]  pin_o, oe, se, pin_i;
  logic [15:0] v;
  logic [31:0] q[$];
  logic [1:0]  spec_bits = 0;
  int          spec_cnt = 0;
  int          failures = 0;
  int          tests_run = 0;
  ccu_top ccu_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timebase16_inc_i(inc), .unit_pin_i(pin_i), .port_direction_i(dir),
    .port_data_i(pdat), .unit_pin_o(pin_o), .unit_pin_oe_o(oe), .special_event_o(se));
  ccu_pin_model ccu_pin_model_i (.src_i(src), .drv_i(pin_o), .oe_i(oe), .pin_o(pin_i));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic end_of_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    if (!w)
      q.push_back(d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= w ? d : 32'h0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack && n < 20);
    if (!ack) begin
      failures++;
      end_of_test();
    end
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int u);
    src[u] <= 1'b1;
    repeat (6) @(posedge clk_i);
    src[u] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (ack && !we && cyc && q.size() > 0)
      chk("read", q.pop_front(), rdat);
  end
  always @(posedge clk_i) begin
    if (|se) begin
      spec_cnt <= spec_cnt + 1;
      spec_bits <= se;
    end
  end
  initial begin
    v = 16'($urandom(69323));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, `CCU_ADR_CTL1, 32'h0);
    bus(1, 8'h40, 32'hFF);
    bus(0, 8'h40, 32'h0);
    for (int u = 0; u < 2; u++) begin
      ctl = u ? `CCU_ADR_CTL2 : `CCU_ADR_CTL1;
      for (int m = 4; m < 8; m++) begin
        v = 16'($urandom);
        bus(1, ctl, 32'h0);
        bus(1, ctl, 32'(m));
        bus(1, `CCU_ADR_FLAG, 32'h0);
        bus(1, `CCU_ADR_TBASE, {16'h0, v});
        repeat (m == 7 ? 15 : m == 6 ? 3 : 0) pulse(u);
        bus(0, `CCU_ADR_FLAG, 32'h0);
        pulse(u);
        bus(0, `CCU_ADR_FLAG, 32'h4 << u);
        bus(0, 8'(`CCU_ADR_VAL1 + 4 * u), {16'h0, v});
      end
    end
    bus(1, `CCU_ADR_CTL1, 32'h0);
    bus(1, `CCU_ADR_CTL1, 32'h5);
    bus(1, `CCU_ADR_FLAG, 32'h0);
    for (int i = 0; i < 2; i++) begin
      v = 16'($urandom);
      bus(1, `CCU_ADR_TBASE, {16'h0, v});
      pulse(0);
    end
    bus(0, `CCU_ADR_VAL1, {16'h0, v});
    bus(0, `CCU_ADR_FLAG, 32'h4);
    dir <= 2'h2;
    bus(1, `CCU_ADR_FLAG, 32'h0);
    pdat <= 2'h1;
    repeat (8) @(posedge clk_i);
    bus(0, `CCU_ADR_FLAG, 32'h4);
    pdat <= 2'h0;
    v = 16'($urandom) | 16'h0100;
    bus(1, `CCU_ADR_CTL1, 32'h0);
    bus(1, `CCU_ADR_VAL1, {16'h0, v});
    bus(1, `CCU_ADR_TBASE, {16'h0, v});
    for (int i = 0; i < 3; i++) begin
      bus(1, `CCU_ADR_CTL1, i == 0 ? 32'h8 : i == 1 ? 32'hA : 32'h9);
      bus(1, `CCU_ADR_FLAG, 32'h0);
      chk("pin", {31'h0, i < 2}, {31'h0, pin_o[0]});
      bus(0, `CCU_ADR_FLAG, 32'h4);
    end
    pdat <= 2'h1;
    bus(1, `CCU_ADR_CTL1, 32'hFF);
    bus(0, `CCU_ADR_CTL1, 32'h3F);
    chk("pwm pin", 32'h1, {31'h0, pin_o[0]});
    pdat <= 2'h0;
    for (int u = 0; u < 2; u++) begin
      bus(1, `CCU_ADR_CTL1, 32'h0);
      bus(1, `CCU_ADR_CTL2, 32'h0);
      bus(1, `CCU_ADR_FLAG, 32'h0);
      bus(1, 8'(`CCU_ADR_VAL1 + 4 * u), {16'h0, v});
      bus(1, `CCU_ADR_TBASE, {16'h0, v});
      bus(1, u ? `CCU_ADR_CTL2 : `CCU_ADR_CTL1, 32'hB);
      bus(0, `CCU_ADR_TBASE, 32'h0);
      chk("special unit", {30'h0, 2'h1 << u}, {30'h0, spec_bits});
      chk("special count", u + 1, spec_cnt);
      bus(0, `CCU_ADR_FLAG, 32'h4 << u);
    end
    bus(1, `CCU_ADR_TBASE, 32'h0);
    inc <= 1'b1;
    repeat (10) @(posedge clk_i);
    inc <= 1'b0;
    bus(0, `CCU_ADR_TBASE, 32'hA);
    end_of_test();
  end
endmodule
